// File: verilog/conv_seq_pkg.sv
package conv_seq_pkg;

  // ==========================================================================
  // Field widths and layouts
  // ==========================================================================
  localparam int CHANNEL_W = 5;
  localparam logic [4:0] CHANNEL_OFF = 5'h1f;
  localparam int RESULT_W = 12;

  // Resolution mode field encodings.
  localparam logic [1:0] MODE_8BIT = 2'h0;
  localparam logic [1:0] MODE_12BIT = 2'h1;
  localparam logic [1:0] MODE_10BIT = 2'h2;

  // Input clock select encodings.
  localparam logic [1:0] CLK_BUS = 2'h0;
  localparam logic [1:0] CLK_BUS_DIV2 = 2'h1;
  localparam logic [1:0] CLK_ALT = 2'h2;
  localparam logic [1:0] CLK_ASYNC = 2'h3;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [7:0] RESULT_HIGH_RESET = 8'h00;
  localparam logic [7:0] RESULT_LOW_RESET = 8'h00;

  // ==========================================================================
  // Timing, in conversion clock cycles; async startup in us and core clock cycles
  // ==========================================================================
  // Sample phase counts in half cycles: 3.5 and 23.5 cycles.
  localparam logic [5:0] SAMPLE_SHORT_HALF = 6'h07;
  localparam logic [5:0] SAMPLE_LONG_HALF = 6'h2f;
  // Approximation steps per resolution.
  localparam logic [3:0] STEPS_8BIT = 4'h9;
  localparam logic [3:0] STEPS_12BIT = 4'hc;
  // Startup of the asynchronous clock generator.
  localparam int ASYNC_START_US = 5;
  localparam int CORE_CLK_MHZ = 125;
  localparam int ASYNC_START_CYCLES = ASYNC_START_US * CORE_CLK_MHZ;
  localparam logic [9:0] ASYNC_START_COUNT = 10'(ASYNC_START_CYCLES);

  // ==========================================================================
  // Controller states
  // ==========================================================================
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_STARTUP,
    ST_SAMPLE,
    ST_CONVERT,
    ST_TRANSFER
  } seq_state_t;

endpackage

// File: verilog/conv_clock_divider.sv
`timescale 1ns/1ps
module conv_clock_divider (
  input  wire logic       core_clk,
  input  wire logic       resetn,
  input  wire logic       run,
  input  wire logic [1:0] clock_divide_select,
  input  wire logic       src_tick,
  output logic            half_tick
);

  // ==========================================================================
  // Half-cycle enable of the conversion clock
  // ==========================================================================
  logic [3:0] count;
  logic [3:0] limit;

  // The divider produces two ticks per conversion clock period so the half
  // cycle of the sample phase can be counted exactly.
  always_comb begin
    case (clock_divide_select)
      2'h0:    limit = 4'h0;
      2'h1:    limit = 4'h1;
      2'h2:    limit = 4'h3;
      default: limit = 4'h7;
    endcase
  end

  // Held cleared while idle so each conversion started from idle begins on a known phase.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      count     <= 4'h0;
      half_tick <= 1'b0;
    end else if (!run) begin
      count     <= 4'h0;
      half_tick <= 1'b0;
    end else if (src_tick) begin
      half_tick <= (count == limit);
      count     <= (count == limit) ? 4'h0 : count + 4'h1;
    end else begin
      half_tick <= 1'b0;
    end
  end

endmodule

// File: verilog/conv_sar_engine.sv
`timescale 1ns/1ps
module conv_sar_engine (
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        start,
  input  wire logic        step,
  input  wire logic [3:0]  steps,
  input  wire logic        comparator_high,
  output logic [11:0]      value,
  output logic             done
);

  // ==========================================================================
  // Successive approximation register
  // ==========================================================================
  logic [3:0]  bit_index;
  logic        busy;

  // One trial bit per conversion clock; the comparator answers whether the
  // held input is above the trial level. Bits fill downward from bit steps minus one.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      value     <= 12'h000;
      bit_index <= 4'h0;
      busy      <= 1'b0;
      done      <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        value     <= 12'h000;
        bit_index <= steps;
        busy      <= 1'b1;
      end else if (busy && step) begin
        value[4'(bit_index - 4'h1)] <= comparator_high;
        bit_index <= bit_index - 4'h1;
        if (bit_index == 4'h1) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end

endmodule

// File: verilog/adc_conversion_sequencer.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Control-one write aborts, restarts unless channel off or hardware trigger selected.
// - Other control writes abort as mode change.
// - Reset or stop without async clock aborts.
// - Abort keeps results; reset clears them.
// - Idle until start; async clock only when chosen.
// - Sample 3.5 or 23.5 conversion clocks.
// - Isolate, approximate, then transfer result.
// - Slow bus loosens continuous sample timing.
// - First conversion within cycle budget.
// - Async clock adds 5 us startup.
// - Later continuous conversions skip startup overhead.
// - Compare sets flag per greater select.
// - Compare stores difference, not raw result.
// - False compare: no flag, no transfer.
// - Interrupt when flag sets and enabled.
// - Wait mode finishes and accepts new starts.
// - Completion in wait wakes by interrupt.
// - Stop3 without async aborts, keeps results.
// - Stop3 with async keeps converting.
// - Stop2 returns everything to reset.
// - Half-read result blocks transfer, discards result.
// - Rising trigger starts; edges ignored while busy.
module adc_conversion_sequencer (
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        write_control_one,
  input  wire logic        write_control_two,
  input  wire logic        write_configuration,
  input  wire logic        write_compare_high,
  input  wire logic        write_compare_low,
  input  wire logic [7:0]  write_data,
  input  wire logic        read_result_high,
  input  wire logic        read_result_low,
  input  wire logic        hardware_trigger_input,
  input  wire logic        alternate_clock,
  input  wire logic        comparator_high,
  input  wire logic        wait_mode,
  input  wire logic        stop3_mode,
  input  wire logic        stop2_mode,
  output logic [7:0]       result_high,
  output logic [7:0]       result_low,
  output logic             conversion_complete_flag,
  output logic             conversion_active,
  output logic             conversion_irq,
  output logic             internal_async_conv_clock_enable,
  output logic             analog_sample_enable,
  output logic [4:0]       analog_channel
);

  // ==========================================================================
  // Register fields
  // ==========================================================================
  logic [4:0]  channel_select;
  logic        complete_interrupt_enable;
  logic        continuous_conversion_enable;
  logic        hardware_trigger_select;
  logic        compare_function_enable;
  logic        compare_greater_select;
  logic        low_power_config;
  logic [1:0]  clock_divide_select;
  logic        long_sample_select;
  logic [1:0]  resolution_mode;
  logic [1:0]  input_clock_select;
  logic [3:0]  compare_value_high;
  logic [7:0]  compare_value_low;

  conv_seq_pkg::seq_state_t state;
  logic        soft_reset;
  logic        mode_write;
  logic        stop_abort;
  logic        abort;
  logic        first_conv;
  logic        read_pending;
  logic [5:0]  sample_half;
  logic [9:0]  startup_count;
  logic        half_tick;
  logic        conv_step;
  logic        step_phase;
  logic [11:0] sar_value;
  logic        sar_done;
  logic        sar_start;
  logic [1:0]  trig_sync;
  logic [1:0]  alt_sync;
  logic        trig_last;
  logic        alt_last;
  logic        bus_half;
  logic        src_tick;
  logic        async_phase;
  logic        start_request;
  logic [11:0] aligned;
  logic [12:0] difference;
  logic        compare_true;
  logic        complete_set;

  // Stop2 acts as a full reset of the module's state.
  assign soft_reset = stop2_mode;
  assign mode_write = write_control_two | write_configuration | write_compare_high
                    | write_compare_low;
  assign stop_abort = stop3_mode && (input_clock_select != conv_seq_pkg::CLK_ASYNC);
  assign abort = write_control_one | mode_write | stop_abort;

  // ==========================================================================
  // Software-visible control registers
  // ==========================================================================
  // Writes land one byte at a time; the order in which software performs
  // them is its own affair, each write simply aborts what is running.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      channel_select               <= conv_seq_pkg::CHANNEL_OFF;
      complete_interrupt_enable    <= 1'b0;
      continuous_conversion_enable <= 1'b0;
      hardware_trigger_select      <= 1'b0;
      compare_function_enable      <= 1'b0;
      compare_greater_select       <= 1'b0;
      low_power_config             <= 1'b0;
      clock_divide_select          <= 2'h0;
      long_sample_select           <= 1'b0;
      resolution_mode              <= conv_seq_pkg::MODE_8BIT;
      input_clock_select           <= conv_seq_pkg::CLK_BUS;
      compare_value_high           <= 4'h0;
      compare_value_low            <= 8'h00;
    end else if (soft_reset) begin
      channel_select               <= conv_seq_pkg::CHANNEL_OFF;
      complete_interrupt_enable    <= 1'b0;
      continuous_conversion_enable <= 1'b0;
      hardware_trigger_select      <= 1'b0;
      compare_function_enable      <= 1'b0;
      compare_greater_select       <= 1'b0;
      low_power_config             <= 1'b0;
      clock_divide_select          <= 2'h0;
      long_sample_select           <= 1'b0;
      resolution_mode              <= conv_seq_pkg::MODE_8BIT;
      input_clock_select           <= conv_seq_pkg::CLK_BUS;
      compare_value_high           <= 4'h0;
      compare_value_low            <= 8'h00;
    end else begin
      if (write_control_one) begin
        complete_interrupt_enable    <= write_data[6];
        continuous_conversion_enable <= write_data[5];
        channel_select               <= write_data[4:0];
      end
      if (write_control_two) begin
        hardware_trigger_select <= write_data[6];
        compare_function_enable <= write_data[5];
        compare_greater_select  <= write_data[4];
      end
      if (write_configuration) begin
        low_power_config    <= write_data[7];
        clock_divide_select <= write_data[6:5];
        long_sample_select  <= write_data[4];
        resolution_mode     <= write_data[3:2];
        input_clock_select  <= write_data[1:0];
      end
      if (write_compare_high) begin
        compare_value_high <= write_data[3:0];
      end
      if (write_compare_low) begin
        compare_value_low <= write_data;
      end
    end
  end

  // ==========================================================================
  // Input synchronisers and conversion clock source
  // ==========================================================================
  // Trigger and alternate clock come from outside the domain.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      trig_sync <= 2'h0;
      alt_sync  <= 2'h0;
      trig_last <= 1'b0;
      alt_last  <= 1'b0;
    end else begin
      trig_sync <= {trig_sync[0], hardware_trigger_input};
      alt_sync  <= {alt_sync[0], alternate_clock};
      trig_last <= trig_sync[1];
      alt_last  <= alt_sync[1];
    end
  end

  // The asynchronous source is modelled as half the core rate; it only runs
  // while enabled, which keeps the generator off in every idle state.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      bus_half    <= 1'b0;
      async_phase <= 1'b0;
    end else begin
      bus_half    <= ~bus_half;
      async_phase <= internal_async_conv_clock_enable ? ~async_phase : 1'b0;
    end
  end

  always_comb begin
    case (input_clock_select)
      conv_seq_pkg::CLK_BUS:      src_tick = 1'b1;
      conv_seq_pkg::CLK_BUS_DIV2: src_tick = bus_half;
      conv_seq_pkg::CLK_ALT:      src_tick = alt_sync[1] & ~alt_last;
      default:                    src_tick = async_phase;
    endcase
  end

  conv_clock_divider u_divider (
    .core_clk            (core_clk),
    .resetn              (resetn),
    .run                 (state != conv_seq_pkg::ST_IDLE),
    .clock_divide_select (clock_divide_select),
    .src_tick            (src_tick),
    .half_tick           (half_tick)
  );

  // Every second half tick is a whole conversion clock step.
  assign conv_step = half_tick & step_phase;

  // ==========================================================================
  // Start requests
  // ==========================================================================
  // Trigger edges count only in idle; during a conversion they are dropped.
  assign start_request = (hardware_trigger_select && trig_sync[1] && !trig_last
                          && state == conv_seq_pkg::ST_IDLE);

  // ==========================================================================
  // Compare arithmetic
  // ==========================================================================
  // Eight-bit mode keeps the truncated top byte, bits 11 to 4; wider modes align to the word.
  always_comb begin
    case (resolution_mode)
      conv_seq_pkg::MODE_8BIT:  aligned = {4'h0, sar_value[11:4]};
      conv_seq_pkg::MODE_10BIT: aligned = {2'h0, sar_value[11:2]};
      default:                  aligned = sar_value;
    endcase
    difference   = {1'b0, aligned} + {1'b0, ~{compare_value_high, compare_value_low}} + 13'h0001;
    // A carry out means result >= compare value.
    compare_true = compare_greater_select ? difference[12] : !difference[12];
  end

  assign complete_set = (state == conv_seq_pkg::ST_TRANSFER) && !read_pending
                      && (!compare_function_enable || compare_true);

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  // Abort has priority over completion: a result in flight is simply lost.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state         <= conv_seq_pkg::ST_IDLE;
      first_conv    <= 1'b1;
      sample_half   <= 6'h00;
      startup_count <= 10'h000;
      step_phase    <= 1'b0;
      sar_start     <= 1'b0;
    end else if (soft_reset) begin
      state <= conv_seq_pkg::ST_IDLE;
      first_conv <= 1'b1;
      sar_start  <= 1'b0;
    end else begin
      sar_start <= 1'b0;
      if (abort) begin
        state      <= conv_seq_pkg::ST_IDLE;
        first_conv <= 1'b1;
        if (write_control_one && write_data[4:0] != conv_seq_pkg::CHANNEL_OFF && !hardware_trigger_select) begin
          state <= (input_clock_select == conv_seq_pkg::CLK_ASYNC) ? conv_seq_pkg::ST_STARTUP
                   : conv_seq_pkg::ST_SAMPLE;
          startup_count <= conv_seq_pkg::ASYNC_START_COUNT;
          sample_half   <= 6'h00;
        end
      end else begin
        case (state)
          conv_seq_pkg::ST_IDLE: begin
            if (start_request && channel_select != conv_seq_pkg::CHANNEL_OFF) begin
              state <= (input_clock_select == conv_seq_pkg::CLK_ASYNC) ? conv_seq_pkg::ST_STARTUP
                       : conv_seq_pkg::ST_SAMPLE;
              startup_count <= conv_seq_pkg::ASYNC_START_COUNT;
              sample_half   <= 6'h00;
              first_conv    <= 1'b1;
            end
          end
          conv_seq_pkg::ST_STARTUP: begin
            // The generator needs its startup time before the first sample.
            if (startup_count == 10'h000) begin
              state <= conv_seq_pkg::ST_SAMPLE;
            end else begin
              startup_count <= startup_count - 10'h001;
            end
          end
          conv_seq_pkg::ST_SAMPLE: begin
            if (half_tick) begin
              sample_half <= sample_half + 6'h01;
              if (sample_half == (long_sample_select ? conv_seq_pkg::SAMPLE_LONG_HALF
                                                     : conv_seq_pkg::SAMPLE_SHORT_HALF) - 6'h01) begin
                state      <= conv_seq_pkg::ST_CONVERT;
                sar_start  <= 1'b1;
                step_phase <= 1'b0;
              end
            end
          end
          conv_seq_pkg::ST_CONVERT: begin
            if (half_tick) begin
              step_phase <= ~step_phase;
            end
            if (sar_done) begin
              state <= conv_seq_pkg::ST_TRANSFER;
            end
          end
          conv_seq_pkg::ST_TRANSFER: begin
            // A blocked transfer always relaunches, except a failed single
            // compare, which ends the run.
            first_conv  <= 1'b0;
            sample_half <= 6'h00;
            if (read_pending && !(compare_function_enable && !compare_true && !continuous_conversion_enable)) begin
              state <= conv_seq_pkg::ST_SAMPLE;
            end else if (continuous_conversion_enable) begin
              state <= conv_seq_pkg::ST_SAMPLE;
            end else begin
              state <= conv_seq_pkg::ST_IDLE;
            end
          end
          default: state <= conv_seq_pkg::ST_IDLE;
        endcase
      end
    end
  end

  conv_sar_engine u_sar (
    .core_clk        (core_clk),
    .resetn          (resetn),
    .start           (sar_start),
    .step            (conv_step),
    .steps           ((resolution_mode == conv_seq_pkg::MODE_8BIT) ? conv_seq_pkg::STEPS_8BIT
                      : conv_seq_pkg::STEPS_12BIT),
    .comparator_high (comparator_high),
    .value           (sar_value),
    .done            (sar_done)
  );

  // ==========================================================================
  // Result registers, flag and read blocking
  // ==========================================================================
  // Aborts leave the result untouched; only reset and stop2 clear it.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      result_high <= conv_seq_pkg::RESULT_HIGH_RESET;
      result_low  <= conv_seq_pkg::RESULT_LOW_RESET;
    end else if (soft_reset) begin
      result_high <= conv_seq_pkg::RESULT_HIGH_RESET;
      result_low  <= conv_seq_pkg::RESULT_LOW_RESET;
    end else if (complete_set && !abort) begin
      result_high <= compare_function_enable ? {4'h0, difference[11:8]} : {4'h0, aligned[11:8]};
      result_low  <= compare_function_enable ? difference[7:0] : aligned[7:0];
    end
  end

  // The flag clears on a control-one write; a completion in that cycle is
  // suppressed anyway by the abort, so no set is lost to the clear.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      conversion_complete_flag <= 1'b0;
      read_pending             <= 1'b0;
    end else if (soft_reset) begin
      conversion_complete_flag <= 1'b0;
      read_pending             <= 1'b0;
    end else begin
      if (complete_set && !abort) begin
        conversion_complete_flag <= 1'b1;
      end else if (write_control_one || read_result_low) begin
        conversion_complete_flag <= 1'b0;
      end
      // Blocking only applies to the two-byte modes.
      if (read_result_low) begin
        read_pending <= 1'b0;
      end else if (read_result_high && resolution_mode != conv_seq_pkg::MODE_8BIT) begin
        read_pending <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  // The interrupt is a level that follows the enabled flag, which wakes the
  // system from wait or stop3 alike.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      conversion_irq                   <= 1'b0;
      conversion_active                <= 1'b0;
      internal_async_conv_clock_enable <= 1'b0;
      analog_sample_enable             <= 1'b0;
      analog_channel                   <= conv_seq_pkg::CHANNEL_OFF;
    end else begin
      conversion_irq <= complete_interrupt_enable
                        && (conversion_complete_flag || (complete_set && !abort));
      conversion_active <= (state != conv_seq_pkg::ST_IDLE);
      internal_async_conv_clock_enable <= (state != conv_seq_pkg::ST_IDLE) && !soft_reset
                                          && (input_clock_select == conv_seq_pkg::CLK_ASYNC);
      analog_sample_enable <= (state == conv_seq_pkg::ST_SAMPLE);
      analog_channel       <= channel_select;
    end
  end

endmodule

// File: testbench/analog_source_model.sv
`timescale 1ns/1ps
// ====
// Far side: a channel held at the low reference.
module analog_source_model (
  input  wire logic core_clk,
  output logic      comparator_high
);
  // A steady input answers every trial step low.
  always_ff @(posedge core_clk) comparator_high <= 1'b0;
endmodule

// File: testbench/seq_checker_asserts.sv
`timescale 1ns/1ps
// ====
// Port checks.
module seq_checker (
  input wire logic       core_clk,
  input wire logic       resetn,
  input wire logic       write_control_one,
  input wire logic       write_configuration,
  input wire logic [7:0] write_data,
  input wire logic       stop2_mode,
  input wire logic [7:0] result_high,
  input wire logic [7:0] result_low,
  input wire logic       conversion_complete_flag,
  input wire logic       conversion_active,
  input wire logic       internal_async_conv_clock_enable,
  input wire logic       conversion_irq,
  input wire logic       analog_sample_enable
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // Activity lags the state by one cycle, so an abort shows two cycles on.
  chk_cfg_abort: assert property (write_configuration |-> ##2 !conversion_active) else $error("no abort");
  chk_off_idle: assert property (write_control_one && write_data[4:0] == 5'h1f |-> ##2 !conversion_active)
    else $error("started");
  chk_flag_clear: assert property (write_control_one |=> !conversion_complete_flag) else $error("flag");
  chk_stop_reset: assert property (stop2_mode |=> {result_high, result_low} == 16'h0000) else $error("kept");
  // A write or an abort may cut sampling short; otherwise it lasts at least 7 core clock cycles.
  chk_sample_len: assert property (disable iff (!resetn || write_control_one)
    $rose(analog_sample_enable) |-> (analog_sample_enable || !conversion_active)[*7]) else $error("short");
  chk_async_gate: assert property (internal_async_conv_clock_enable |-> conversion_active) else $error("async");
  chk_irq_drop: assert property (conversion_irq |-> conversion_complete_flag || $past(conversion_complete_flag))
    else $error("irq");
  chk_irq_rise: assert property ($rose(conversion_irq) |-> conversion_complete_flag) else $error("irq rise");
  chk_flag_busy: assert property ($rose(conversion_complete_flag) |-> $past(conversion_active)) else $error("idle");
endmodule
bind adc_conversion_sequencer seq_checker chk_i (.*);

// File: testbench/testbench.sv
`timescale 1ns/1ps
// ====
// Directed bench; bits of wsel strobe the writes and reads.
module testbench;
  logic       core_clk = 0, resetn = 0, stop3 = 0, stop2 = 0, cmp, flag, irq;
  logic [6:0] wsel = 7'h00;
  logic [7:0] wd = 8'h00, rh, rl;
  logic [4:0] ch;
  logic       trig = 0, wt = 0;
  int         fails = 0, check_count = 0;
  logic [7:0] cfgs [3] = '{8'h00, 8'h18, 8'h03};
  int         lims [3] = '{43, 89, 708};
  // Clock of 8 ns.
  initial forever #4 core_clk = ~core_clk;
  adc_conversion_sequencer dut (.core_clk(core_clk), .resetn(resetn), .write_control_one(wsel[0]),
    .write_control_two(wsel[1]), .write_configuration(wsel[2]), .write_compare_high(wsel[3]),
    .write_compare_low(wsel[4]), .write_data(wd), .read_result_high(wsel[5]), .read_result_low(wsel[6]),
    .hardware_trigger_input(trig), .alternate_clock(1'b0), .comparator_high(cmp), .wait_mode(wt),
    .stop3_mode(stop3), .stop2_mode(stop2), .result_high(rh), .result_low(rl), .conversion_irq(irq),
    .conversion_complete_flag(flag), .conversion_active(), .internal_async_conv_clock_enable(),
    .analog_sample_enable(), .analog_channel(ch));
  analog_source_model partner (.core_clk(core_clk), .comparator_high(cmp));
  // One-cycle strobe; the idle edge after it keeps strobes apart.
  task automatic wr(input int k, input logic [7:0] d);
    @(posedge core_clk);
    wsel <= 7'(1 << k);
    wd <= d;
    @(posedge core_clk);
    wsel <= 7'h00;
  endtask
  // Bounded wait for the flag, then irq, flag and result compared at mid-cycle.
  task automatic wdone(input int lim, input logic [17:0] exp);
    @(negedge core_clk);
    for (int n = 0; n < lim && flag !== 1'b1; n++) @(negedge core_clk);
    check_count++;
    if ({irq, flag, rh, rl} !== exp) begin
      fails++;
      $display("MISMATCH %0t %h %h", $time, {irq, flag, rh, rl}, exp);
    end
  endtask
  // Zero input converts to zero within the budget of each setup.
  task automatic t_time(input logic [7:0] cfg, input int lim);
    wr(2, cfg);
    wr(0, 8'h41);
    wdone(lim, 18'h30000);
    wr(6, 8'h00);
  endtask
  // Continuous runs relaunch without startup; channel off stops them.
  task automatic t_cont();
    wr(2, 8'h00);
    wr(0, 8'h61);
    wdone(43, 18'h30000);
    wr(6, 8'h00);
    wdone(34, 18'h30000);
    wr(0, 8'h7f);
    wdone(60, 18'h00000);
  endtask
  // Limit 5: below it stores 0 minus 5; above it keeps old data.
  // A pending high-byte read then blocks and discards until the low byte is read.
  task automatic t_cmp();
    wr(2, 8'h04);
    wr(4, 8'h05);
    wr(1, 8'h20);
    wr(0, 8'h01);
    wdone(80, 18'h10ffb);
    wr(5, 8'h00);
    wr(1, 8'h30);
    wr(0, 8'h01);
    wdone(80, 18'h00ffb);
    wr(4, 8'h07);
    wr(1, 8'h20);
    wr(0, 8'h01);
    wdone(80, 18'h00ffb);
    wr(6, 8'h00);
    wdone(80, 18'h10ff9);
  endtask
  // Mode change and stop3 keep results; stop2 clears them.
  task automatic t_abort();
    wr(1, 8'h00);
    wr(0, 8'h01);
    wr(2, 8'h04);
    wdone(60, 18'h00ff9);
    wr(0, 8'h01);
    @(posedge core_clk) stop3 <= 1'b1;
    wdone(60, 18'h00ff9);
    @(posedge core_clk) stop3 <= 1'b0;
    @(posedge core_clk) stop2 <= 1'b1;
    @(posedge core_clk) stop2 <= 1'b0;
    wdone(2, 18'h00000);
  endtask
  // A trigger edge starts a conversion in wait mode; an edge while busy is lost.
  task automatic t_trig();
    wr(1, 8'h40);
    wr(0, 8'h41);
    @(posedge core_clk) trig <= 1'b1;
    wt <= 1'b1;
    repeat (12) @(posedge core_clk);
    trig <= 1'b0;
    repeat (2) @(posedge core_clk);
    trig <= 1'b1;
    wdone(43, 18'h30000);
    check_count++;
    if (ch !== 5'h01) begin
      fails++;
      $display("MISMATCH %0t %h %h", $time, ch, 5'h01);
    end
    wr(6, 8'h00);
    wdone(60, 18'h00000);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Two reset cycles, then scenarios.
  initial begin
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    foreach (cfgs[i]) t_time(cfgs[i], lims[i]);
    t_cont();
    t_cmp();
    t_abort();
    t_trig();
    conclude();
  end
  // Run needs about 1400 cycles.
  initial begin
    #100000;
    fails++;
    conclude();
  end
endmodule
